// File: accr_map.vh
`ifndef ACCR_MAP_VH
`define ACCR_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ACCR_OFS_PHASE      8'h40
`define ACCR_OFS_INPUT      8'h41

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ACCR_RST_PHASE      8'h00
`define ACCR_RST_INPUT      8'h00

// ----------------------------------------------------------------------
// input setup field positions
// ----------------------------------------------------------------------
`define ACCR_BIT_LINE       7
`define ACCR_SRC_HI         6
`define ACCR_SRC_LO         5
`define ACCR_BIT_DC         4
`define ACCR_IMP_HI         3
`define ACCR_IMP_LO         2
`define ACCR_BIT_RSVD       1
`define ACCR_BIT_AGC        0

// ----------------------------------------------------------------------
// source and impedance codes
// ----------------------------------------------------------------------
`define ACCR_SRC_DIFF       2'h0
`define ACCR_SRC_SINGLE     2'h1
`define ACCR_SRC_PDM        2'h2
`define ACCR_IMP_10K        2'h1
`define ACCR_IMP_20K        2'h2

// ----------------------------------------------------------------------
// delay line depth
// ----------------------------------------------------------------------
`define ACCR_DELAY_MAX      255

`endif

// File: accr_phase_delay.v
`timescale 1ns/10ps
`include "accr_map.vh"

// variable delay of one sample stream, advanced on modulator enable
module accr_phase_delay #(
  parameter DEPTH = `ACCR_DELAY_MAX
) (
  clk,
  arst_n,
  mod_en,
  delay,
  sample_in,
  sample_out
);
  input  wire       clk;
  input  wire       arst_n;
  input  wire       mod_en;
  input  wire [7:0] delay;
  input  wire       sample_in;
  output reg        sample_out;

  reg [DEPTH-1:0] line;

  // ----------------------------------------------------------------------
  // shift line, tap chosen by delay
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line       <= {DEPTH{1'b0}};
      sample_out <= 1'b0;
    end else if (mod_en) begin
      line <= {line[DEPTH-2:0], sample_in};
      if (delay == 8'h00) begin
        sample_out <= sample_in; // RQ1
      end else begin
        sample_out <= line[delay - 8'h01]; // RQ1
      end
    end
  end
endmodule // accr_phase_delay

// File: accr_channel_config.v
// What this block does
// RQ1: channel 1 delayed by phase field, 0 to 255 modulator cycles
// RQ2: bit 7 low selects microphone, high selects line input
// RQ3: bits 6-5 choose differential, single-ended or PDM source
// RQ4: software keeps general pins disabled for analog source modes
// RQ5: software routes general pins to PDM data and clock for PDM
// RQ6: bits 3-2 set impedance, one gives 10k, two gives 20k
// RQ7: bit 1 reserved, reads zero, software writes zero
// RQ8: bit 0 enables channel 2 AGC per page0_reg_108 bit 3
// RQ9: phase delay register at 0x40, read/write, resets to zero
// RQ10: input setup register at 0x41, resets to zero
// RQ11: dc bit 4 stored read/write, resets to zero
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "accr_map.vh"

module accr_channel_config (
  clk,
  arst_n,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  mod_en,
  first_channel_in,
  first_channel_out,
  page0_reg_108_agc,
  second_channel_line_select,
  second_channel_source_select,
  second_channel_pdm_active,
  second_channel_dc_bit,
  second_channel_impedance,
  impedance_10k,
  impedance_20k,
  second_channel_auto_gain_on
);
  input  wire       clk;
  input  wire       arst_n;
  input  wire [7:0] addr;
  input  wire [7:0] wdata;
  input  wire       wr;
  input  wire       rd;
  output reg  [7:0] rdata;
  input  wire       mod_en;
  input  wire       first_channel_in;
  output wire       first_channel_out;
  input  wire       page0_reg_108_agc;
  output reg        second_channel_line_select;
  output reg  [1:0] second_channel_source_select;
  output reg        second_channel_pdm_active;
  output reg        second_channel_dc_bit;
  output reg  [1:0] second_channel_impedance;
  output reg        impedance_10k;
  output reg        impedance_20k;
  output reg        second_channel_auto_gain_on;

  // ----------------------------------------------------------------------
  // stored registers, next values and decode nets
  // ----------------------------------------------------------------------
  reg  [7:0] first_channel_phase_delay;
  reg  [7:0] input_setup;
  reg  [7:0] next_first_channel_phase_delay;
  reg  [7:0] next_input_setup;
  reg  [7:0] next_rdata;

  // next values of the decoded controls
  reg        next_line_select;
  reg  [1:0] next_source_select;
  reg        next_pdm_active;
  reg        next_dc_bit;
  reg  [1:0] next_impedance;
  reg        next_impedance_10k;
  reg        next_impedance_20k;
  reg        next_auto_gain_on;

  // address decode shared by write and read paths
  wire       hit_phase;
  wire       hit_input;
  wire       wr_phase;
  wire       wr_input;

  // ----------------------------------------------------------------------
  // field helpers
  // ----------------------------------------------------------------------
  // two-bit field of a setup word, low bit given
  function [1:0] field2;
    input [7:0]   word;
    input integer lo;
    begin
      field2 = word[lo +: 2];
    end
  endfunction

  // true when a two-bit field holds the given code
  function code_is;
    input [1:0] field;
    input [1:0] code;
    begin
      code_is = (field == code);
    end
  endfunction

  // writable bits only, reserved bit forced low
  function [7:0] setup_mask;
    input [7:0] word;
    begin
      setup_mask = word & ~(8'h01 << `ACCR_BIT_RSVD); // RQ7
    end
  endfunction

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // exact match, so no alias of the two offsets is mapped
  assign hit_phase = (addr == `ACCR_OFS_PHASE); // RQ9
  assign hit_input = (addr == `ACCR_OFS_INPUT); // RQ10
  assign wr_phase  = wr & hit_phase;
  assign wr_input  = wr & hit_input;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // unmapped writes leave both registers untouched
  always @* begin
    next_first_channel_phase_delay = first_channel_phase_delay;
    next_input_setup               = input_setup;
    if (wr_phase) begin
      next_first_channel_phase_delay = wdata; // RQ9
    end
    if (wr_input) begin
      next_input_setup = setup_mask(wdata); // RQ7 RQ11
    end
  end

  // stored registers, both reset to zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_channel_phase_delay <= `ACCR_RST_PHASE; // RQ9
      input_setup               <= `ACCR_RST_INPUT; // RQ10
    end else begin
      first_channel_phase_delay <= next_first_channel_phase_delay;
      input_setup               <= next_input_setup;
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after strobe, unmapped reads zero
  // ----------------------------------------------------------------------
  // zero whenever no read is under way
  always @* begin
    next_rdata = 8'h00;
    if (rd) begin
      if (hit_phase) begin
        next_rdata = first_channel_phase_delay; // RQ9
      end else if (hit_input) begin
        next_rdata = input_setup; // RQ7 RQ10
      end
    end
  end

  // read data register, stands for one cycle only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // decoded controls toward the analog front end
  // ----------------------------------------------------------------------
  // decode straight from the stored word
  always @* begin
    next_line_select   = input_setup[`ACCR_BIT_LINE]; // RQ2
    next_source_select = field2(input_setup, `ACCR_SRC_LO); // RQ3
    // pdm flag spares the front end a compare of its own
    next_pdm_active    = code_is(field2(input_setup, `ACCR_SRC_LO), `ACCR_SRC_PDM); // RQ3
    next_dc_bit        = input_setup[`ACCR_BIT_DC]; // RQ11
    next_impedance     = field2(input_setup, `ACCR_IMP_LO); // RQ6
    next_impedance_10k = code_is(field2(input_setup, `ACCR_IMP_LO), `ACCR_IMP_10K); // RQ6
    next_impedance_20k = code_is(field2(input_setup, `ACCR_IMP_LO), `ACCR_IMP_20K); // RQ6
    // agc level comes from this clock, so no synchroniser stage
    next_auto_gain_on  = input_setup[`ACCR_BIT_AGC] & page0_reg_108_agc; // RQ8
  end

  // outputs lag the stored word by one clock
  // reset state: differential microphone, agc off
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_channel_line_select   <= 1'b0; // RQ10
      second_channel_source_select <= `ACCR_SRC_DIFF; // RQ10
      second_channel_pdm_active    <= 1'b0;
      second_channel_dc_bit        <= 1'b0;
      second_channel_impedance     <= 2'h0;
      impedance_10k                <= 1'b0;
      impedance_20k                <= 1'b0;
      second_channel_auto_gain_on  <= 1'b0; // RQ10
    end else begin
      second_channel_line_select   <= next_line_select; // RQ2
      second_channel_source_select <= next_source_select; // RQ3
      second_channel_pdm_active    <= next_pdm_active; // RQ3
      second_channel_dc_bit        <= next_dc_bit; // RQ11
      second_channel_impedance     <= next_impedance; // RQ6
      impedance_10k                <= next_impedance_10k; // RQ6
      impedance_20k                <= next_impedance_20k; // RQ6
      second_channel_auto_gain_on  <= next_auto_gain_on; // RQ8
    end
  end

  // ----------------------------------------------------------------------
  // channel 1 phase calibration delay
  // ----------------------------------------------------------------------
  accr_phase_delay #(
    .DEPTH      (`ACCR_DELAY_MAX)
  ) u_delay (
    .clk        (clk),
    .arst_n     (arst_n),
    .mod_en     (mod_en),
    .delay      (first_channel_phase_delay), // RQ1
    .sample_in  (first_channel_in),
    .sample_out (first_channel_out)
  );
endmodule // accr_channel_config

// File: accr_checker.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// register bank port checks
// ----------------------------------------------------------------
module accr_checker (
  input wire       clk,
  input wire       arst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       page0_reg_108_agc,
  input wire       second_channel_line_select,
  input wire [1:0] second_channel_source_select,
  input wire       second_channel_pdm_active,
  input wire       second_channel_dc_bit,
  input wire [1:0] second_channel_impedance,
  input wire       impedance_10k,
  input wire       impedance_20k,
  input wire       second_channel_auto_gain_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // write to input setup register
  wire w41 = wr && addr == 8'h41;
  AST_LINE: assert property (
    w41 |-> ##2 second_channel_line_select == $past(wdata[7], 2)) else $error("line");
  AST_SRC: assert property (
    w41 |-> ##2 second_channel_source_select == $past(wdata[6:5], 2)) else $error("src");
  AST_IMP: assert property (
    w41 |-> ##2 second_channel_impedance == $past(wdata[3:2], 2)) else $error("imp");
  AST_DC: assert property (
    w41 |-> ##2 second_channel_dc_bit == $past(wdata[4], 2)) else $error("dc");
  AST_DEC: assert property (impedance_10k == (second_channel_impedance == 2'h1)
    && impedance_20k == (second_channel_impedance == 2'h2)
    && second_channel_pdm_active == (second_channel_source_select == 2'h2)) else $error("dec");
  AST_RSVD: assert property (
    rd && addr == 8'h41 |=> !rdata[1]) else $error("rsvd");
  AST_AGC_BIT: assert property (
    w41 && !wdata[0] |-> ##2 !second_channel_auto_gain_on) else $error("agc bit");
  AST_AGC_OFF: assert property (
    !page0_reg_108_agc |=> !second_channel_auto_gain_on) else $error("agc off");
  AST_AGC_ON: assert property (
    (w41 && wdata[0]) ##1 page0_reg_108_agc |=> second_channel_auto_gain_on) else $error("agc on");
endmodule // accr_checker

bind accr_channel_config accr_checker u_chk (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
  .page0_reg_108_agc, .second_channel_line_select, .second_channel_source_select,
  .second_channel_pdm_active, .second_channel_dc_bit, .second_channel_impedance,
  .impedance_10k, .impedance_20k, .second_channel_auto_gain_on);

// File: test_audio_channel_config_regs.sv
`timescale 1ns/10ps
module test_audio_channel_config_regs;
  reg        clk = 0, arst_n = 0, wr = 0, rd = 0, mod_en = 0, fin = 0, agc = 0;
  reg  [7:0] addr = 0, wdata = 0;
  reg  [7:0] m [0:1];
  reg        hist [$];
  wire [7:0] rdata;
  wire       fout, line, pdm, dc, i10, i20, gain;
  wire [1:0] src, imp;
  integer    fail_count = 0, cmp_count = 0, i, k;
  always #12.5 clk = ~clk;
  accr_channel_config dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .mod_en(mod_en), .first_channel_in(fin), .first_channel_out(fout),
    .page0_reg_108_agc(agc), .second_channel_line_select(line),
    .second_channel_source_select(src), .second_channel_pdm_active(pdm),
    .second_channel_dc_bit(dc), .second_channel_impedance(imp), .impedance_10k(i10),
    .impedance_20k(i20), .second_channel_auto_gain_on(gain));
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task chk(input [7:0] g, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      if (a[7:1] == 7'h20) m[a[0]] = d & (a[0] ? 8'hfd : 8'hff);
    end
  endtask
  task rreg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 chk(rdata, a[7:1] == 7'h20 ? m[a[0]] : 8'h00);
    end
  endtask
  task finish_test;
    begin
      $display("fail_count %0d cmp_count %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #100000;
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin
    m[0] = 0;
    m[1] = 0;
    k = $urandom(73453);
    repeat (10) @(posedge clk);
    arst_n <= 1;
    for (i = 0; i < 33; i = i + 1) begin
      rreg(8'h40 + i % 3);
      k = $urandom;
      @(posedge clk) agc <= k[8];
      // reserved bit written as zero; source field steps through codes 0, 1 and 2
      wreg(8'h40 + i % 3, {k[7], 2'((i / 3) % 3), k[4:2], 1'b0, k[0]});
      @(posedge clk);
      #1 chk({line, src, dc, imp, 1'b0, gain}, m[1] & {7'h7e, agc});
      chk({5'h0, pdm, i20, i10}, {5'h0, m[1][6:5] == 2, m[1][3:2] == 2, m[1][3:2] == 1});
    end
    for (i = 0; i < 3; i = i + 1) begin
      k = i == 0 ? 0 : i == 1 ? 3 : 255;
      wreg(8'h40, k[7:0]);
      hist.delete();
      repeat (k + 20) begin
        @(posedge clk);
        mod_en <= 1;
        fin <= ^$urandom;
        @(posedge clk);
        hist.push_back(fin);
        mod_en <= 0;
        #1 if (hist.size() > k) chk({7'h0, fout}, {7'h0, hist[hist.size() - 1 - k]});
      end
    end
    @(posedge clk) arst_n <= 0;
    @(posedge clk) arst_n <= 1;
    #1 chk({line, src, dc, imp, i20, gain}, 8'h00);
    chk({5'h0, fout, pdm, i10}, 8'h00);
    m[0] = 0;
    m[1] = 0;
    rreg(8'h40);
    rreg(8'h41);
    finish_test;
  end
endmodule // test_audio_channel_config_regs
